// ### rtl/msff_pkg.sv
package msff_pkg;

  // bank geometry
  localparam int unsigned FILTERS   = 8;
  localparam int unsigned RULES     = 2;
  localparam int unsigned HDR_LEN   = 64;
  localparam int unsigned CNT_W     = 32;

  // fixed header offsets, untagged ipv4/udp frame
  localparam logic [5:0] OFS_DMAC   = 6'h00;
  localparam logic [5:0] OFS_SMAC   = 6'h06;
  localparam logic [5:0] OFS_ETYPE  = 6'h0C;
  localparam logic [5:0] OFS_SIP    = 6'h1A;
  localparam logic [5:0] OFS_DIP    = 6'h1E;
  localparam logic [5:0] OFS_SPORT  = 6'h22;
  localparam logic [5:0] OFS_DPORT  = 6'h24;
  localparam logic [5:0] OFS_LAST   = 6'h3A;
  localparam logic [15:0] ETYPE_IP4 = 16'h0800;

  // base offsets of custom rule kinds
  localparam logic [5:0] BASE_FIXED = 6'h00;
  localparam logic [5:0] BASE_VLAN  = 6'h0C;
  localparam logic [5:0] BASE_IP    = 6'h0E;
  localparam logic [5:0] BASE_UDP   = 6'h22;

  // reset values
  localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    MSFF_BLOCK  = 2'b00,
    MSFF_CUSTOM = 2'b01,
    MSFF_PEER   = 2'b10,
    MSFF_LOOP   = 2'b11
  } msff_fmode_t;

  typedef enum logic [1:0] {
    MSFF_R_OFF    = 2'b00,
    MSFF_R_IGNORE = 2'b01,
    MSFF_R_EQUAL  = 2'b10
  } msff_rmode_t;

  typedef enum logic [2:0] {
    MSFF_K_FIXED = 3'b000,
    MSFF_K_MAC   = 3'b001,
    MSFF_K_CVLAN = 3'b010,
    MSFF_K_SVLAN = 3'b011,
    MSFF_K_IPV4  = 3'b100,
    MSFF_K_IPV6  = 3'b101,
    MSFF_K_UDP   = 3'b110
  } msff_kind_t;

  typedef enum logic [0:0] {
    MSFF_ST_RECV  = 1'b0,
    MSFF_ST_CLASS = 1'b1
  } msff_state_t;

  typedef struct packed {
    logic [7:0] data;
    logic       sof;
    logic       eof;
    logic       tpay;
  } msff_beat_t;

  typedef struct packed {
    msff_rmode_t rmode;
    msff_kind_t  kind;
    logic [5:0]  offset;
    logic [47:0] value;
    logic [47:0] mask;
  } msff_rule_t;

  typedef struct packed {
    msff_fmode_t            fmode;
    msff_rule_t [RULES-1:0] rules;
  } msff_filt_t;

  typedef struct packed {
    logic [47:0] dmac;
    logic [47:0] smac;
    logic [31:0] dip;
    logic [31:0] sip;
    logic [15:0] dport;
    logic [15:0] sport;
  } msff_flow_t;

endpackage

// ### rtl/msff_field_cmp.sv
`timescale 1ns/1ps
module msff_field_cmp
  import msff_pkg::*;
(
  // rule and frame field
  input  wire msff_rule_t rule_i,
  input  wire logic [47:0] field_i,
  input  wire logic        in_range_i,
  // verdict
  output logic             match_o,
  output logic             active_o
);

  logic eq_masked;

  // both sides masked before compare; any mask pattern allowed
  assign eq_masked = ((rule_i.value & rule_i.mask) == (field_i & rule_i.mask)); // RULE_15 RULE_08 RULE_11

  // ignore never matches, equal needs the masked compare
  always_comb
  begin
    active_o = (rule_i.rmode != MSFF_R_OFF);
    match_o  = 1'b0;
    case (rule_i.rmode)
      MSFF_R_EQUAL:  match_o = eq_masked & in_range_i; // RULE_09
      MSFF_R_IGNORE: match_o = 1'b0;                   // RULE_10
      default:       match_o = 1'b0;
    endcase
  end

endmodule

// ### rtl/msff_bank.sv
`timescale 1ns/1ps
// Summary of operation
// RULE_01: eight filters per port, two ports sixteen
// RULE_02: highest priority matching filter takes frame
// RULE_03: block mode never matches any frame
// RULE_04: custom uses typed rules, others fixed
// RULE_05: peer mode matches opposite port flow n
// RULE_06: loop mode swaps addresses and ports
// RULE_07: loop mode uses own port flows only
// RULE_08: only mask bits take part, any pattern
// RULE_09: equal mode selects configured value set
// RULE_10: ignore mode field never matches
// RULE_11: all ones mask gives exact compare
// RULE_12: custom filter holds several rules together
// RULE_13: count frames per filter since start
// RULE_14: flag filter when test payload seen
// RULE_15: value and field both masked first
// RULE_16: all enabled rules must match, before end
// RULE_17: clear results, sample settings at start
module msff_bank
  import msff_pkg::*;
(
  // clock and reset
  input  wire logic                              clk_i,
  input  wire logic                              reset_i,
  // test control and settings
  input  wire logic                              start_i,
  input  wire msff_filt_t [FILTERS-1:0]          cfg_i,
  input  wire msff_flow_t [FILTERS-1:0]          own_flow_i,
  input  wire msff_flow_t [FILTERS-1:0]          peer_flow_i,
  // received frame stream
  input  wire logic                              rx_valid_i,
  input  wire msff_beat_t                        rx_beat_i,
  output logic                                   rx_ready_o,
  // per-filter results and running flag
  output logic [FILTERS-1:0][CNT_W-1:0]          frame_count_o,
  output logic [FILTERS-1:0]                     tpay_seen_o,
  output logic                                   running_o
);

  // six header bytes from a byte offset, zero past the header
  function automatic logic [47:0] hdr48(input logic [HDR_LEN-1:0][7:0] h,
                                        input logic [5:0] ofs);
    logic [47:0] r;
    r = 48'h0000_0000_0000;
    for (int k = 0; k < 6; k++)
    begin
      if (int'(ofs) + k < HDR_LEN)
        r[47-8*k -: 8] = h[int'(ofs) + k];
    end
    return r;
  endfunction

  // base offset of each custom rule kind
  function automatic logic [5:0] kind_base(input msff_kind_t k);
    logic [5:0] b;
    b = BASE_FIXED;
    if (k == MSFF_K_CVLAN || k == MSFF_K_SVLAN)
      b = BASE_VLAN;
    else if (k == MSFF_K_IPV4 || k == MSFF_K_IPV6)
      b = BASE_IP;
    else if (k == MSFF_K_UDP)
      b = BASE_UDP;
    return b;
  endfunction

  msff_state_t                      st_q, st_d;
  logic                             run_q, run_d;
  logic                             rdy_q, rdy_d;
  logic [HDR_LEN-1:0][7:0]          hdr_q, hdr_d;
  logic [6:0]                       idx_q, idx_d;
  logic                             tpay_q, tpay_d;
  msff_filt_t [FILTERS-1:0]         cfg_q, cfg_d;
  logic [FILTERS-1:0][CNT_W-1:0]    cnt_q, cnt_d;
  logic [FILTERS-1:0]               seen_q, seen_d;
  logic [FILTERS-1:0]               match;
  logic [FILTERS-1:0]               win;
  logic [FILTERS-1:0][RULES-1:0]    r_hit, r_act;
  logic [FILTERS-1:0][RULES-1:0][6:0] r_ofs;
  logic [FILTERS-1:0][RULES-1:0]    r_rng;

  // fixed header fields of the buffered frame
  logic [47:0] f_dmac, f_smac;
  logic [31:0] f_sip, f_dip;
  logic [15:0] f_etype, f_sport, f_dport;
  logic [47:0] w_etype, w_sip, w_dip, w_sport, w_dport;

  always_comb
  begin
    f_dmac  = hdr48(hdr_q, OFS_DMAC);
    f_smac  = hdr48(hdr_q, OFS_SMAC);
    w_etype = hdr48(hdr_q, OFS_ETYPE);
    w_sip   = hdr48(hdr_q, OFS_SIP);
    w_dip   = hdr48(hdr_q, OFS_DIP);
    w_sport = hdr48(hdr_q, OFS_SPORT);
    w_dport = hdr48(hdr_q, OFS_DPORT);
    f_etype = w_etype[47:32];
    f_sip   = w_sip[47:16];
    f_dip   = w_dip[47:16];
    f_sport = w_sport[47:32];
    f_dport = w_dport[47:32];
  end

  // one comparator per rule slot of every filter
  for (genvar i = 0; i < FILTERS; i++)
  begin : g_filt
    for (genvar j = 0; j < RULES; j++)
    begin : g_rule
      assign r_ofs[i][j] = 7'(kind_base(cfg_q[i].rules[j].kind)) + 7'(cfg_q[i].rules[j].offset);
      assign r_rng[i][j] = (r_ofs[i][j] <= 7'(OFS_LAST)); // carry kept so big offsets never wrap
      msff_field_cmp u_cmp (
        .rule_i     (cfg_q[i].rules[j]),
        .field_i    (hdr48(hdr_q, r_ofs[i][j][5:0])),
        .in_range_i (r_rng[i][j]),
        .match_o    (r_hit[i][j]),
        .active_o   (r_act[i][j])
      );
    end
  end

  // per-filter verdict by mode
  always_comb
  begin
    match = '0;
    for (int i = 0; i < FILTERS; i++)
    begin
      case (cfg_q[i].fmode)
        MSFF_BLOCK:  match[i] = 1'b0; // RULE_03
        MSFF_CUSTOM: match[i] = (|r_act[i]) && ((r_hit[i] | ~r_act[i]) == '1); // RULE_04 RULE_12 RULE_16
        // generator flow n of the opposite port, as sent
        MSFF_PEER:   match[i] = (f_dmac == peer_flow_i[i].dmac) && // RULE_05
                                (f_smac == peer_flow_i[i].smac) &&
                                (f_etype == ETYPE_IP4) &&
                                (f_sip == peer_flow_i[i].sip) && (f_dip == peer_flow_i[i].dip) &&
                                (f_sport == peer_flow_i[i].sport) &&
                                (f_dport == peer_flow_i[i].dport);
        // own flow n echoed back: every address pair reversed
        MSFF_LOOP:   match[i] = (f_dmac == own_flow_i[i].smac) && // RULE_06 RULE_07
                                (f_smac == own_flow_i[i].dmac) &&
                                (f_etype == ETYPE_IP4) &&
                                (f_dip == own_flow_i[i].sip) && (f_sip == own_flow_i[i].dip) &&
                                (f_dport == own_flow_i[i].sport) &&
                                (f_sport == own_flow_i[i].dport);
        default:     match[i] = 1'b0;
      endcase
    end
  end

  // filter 0 has the highest priority; lower ones never see a taken frame
  always_comb
  begin
    win = '0;
    for (int i = FILTERS - 1; i >= 0; i--)
    begin
      if (match[i])
        win = FILTERS'(1) << i; // RULE_02 RULE_01
    end
  end

  // stream capture and classification sequencing
  always_comb
  begin
    st_d   = st_q;
    run_d  = run_q | start_i;
    rdy_d  = rdy_q;
    hdr_d  = hdr_q;
    idx_d  = idx_q;
    tpay_d = tpay_q;
    cfg_d  = cfg_q;
    cnt_d  = cnt_q;
    seen_d = seen_q;
    case (st_q)
      MSFF_ST_RECV:
      begin
        rdy_d = 1'b1;
        if (rx_valid_i && rdy_q)
        begin
          if (rx_beat_i.sof)
          begin
            hdr_d    = '0;
            hdr_d[0] = rx_beat_i.data;
            idx_d    = 7'd1;
          end
          else if (idx_q < 7'(HDR_LEN))
          begin
            hdr_d[idx_q[5:0]] = rx_beat_i.data;
            idx_d             = idx_q + 7'd1;
          end
          if (rx_beat_i.eof)
          begin
            tpay_d = rx_beat_i.tpay;
            rdy_d  = 1'b0; // hold the stream while the verdict settles
            st_d   = MSFF_ST_CLASS;
          end
        end
      end
      MSFF_ST_CLASS:
      begin
        rdy_d = 1'b1;
        st_d  = MSFF_ST_RECV;
        if (run_q)
        begin
          for (int i = 0; i < FILTERS; i++)
          begin
            if (win[i])
            begin
              cnt_d[i] = cnt_q[i] + 32'h0000_0001; // RULE_13
              if (tpay_q)
                seen_d[i] = 1'b1; // RULE_14
            end
          end
        end
      end
      default: st_d = MSFF_ST_RECV;
    endcase
    // settings frozen between starts; results cleared (start wins)
    if (start_i)
    begin
      cfg_d  = cfg_i;                         // RULE_17
      cnt_d  = {FILTERS{CNT_RST}};             // RULE_17
      seen_d = '0;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      st_q   <= MSFF_ST_RECV;
      run_q  <= 1'b0;
      rdy_q  <= 1'b0;
      hdr_q  <= '0;
      idx_q  <= 7'd0;
      tpay_q <= 1'b0;
      cfg_q  <= '0;
      cnt_q  <= {FILTERS{CNT_RST}};
      seen_q <= '0;
    end
    else
    begin
      st_q   <= st_d;
      run_q  <= run_d;
      rdy_q  <= rdy_d;
      hdr_q  <= hdr_d;
      idx_q  <= idx_d;
      tpay_q <= tpay_d;
      cfg_q  <= cfg_d;
      cnt_q  <= cnt_d;
      seen_q <= seen_d;
    end
  end

  assign rx_ready_o    = rdy_q;
  assign frame_count_o = cnt_q;
  assign tpay_seen_o   = seen_q;
  assign running_o     = run_q;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_one_winner: assert property (st_q == MSFF_ST_CLASS |-> $onehot0(win) && ((win & ~match) == '0)) // RULE_02
    else $error("more than one filter took a frame");
  a_prio_first: assert property (win[1] |-> !match[0]) // RULE_02
    else $error("lower priority filter took a frame");
  a_block_quiet: assert property (cfg_q[6].fmode == MSFF_BLOCK && !start_i |=> $stable(cnt_q[6])) // RULE_03
    else $error("blocked filter counted a frame");
  a_ignore_none: assert property (cfg_q[3].fmode == MSFF_CUSTOM &&
                                  cfg_q[3].rules[0].rmode == MSFF_R_IGNORE |-> !match[3]) // RULE_10
    else $error("ignore rule produced a match");
  a_count_step: assert property (st_q == MSFF_ST_CLASS && run_q && win[0] && !start_i
                                 |=> cnt_q[0] == $past(cnt_q[0]) + 32'h0000_0001) // RULE_13
    else $error("counter did not advance on a taken frame");
  a_tpay_flag: assert property (st_q == MSFF_ST_CLASS && run_q && win[2] && tpay_q && !start_i
                                |=> seen_q[2] ##1 seen_q[2] || $past(start_i)) // RULE_14
    else $error("test payload indication not raised");
  a_start_clear: assert property (start_i |=> cnt_q == '0 && seen_q == '0 && cfg_q == $past(cfg_i)) // RULE_17
    else $error("start did not clear results and load settings");
  a_cfg_frozen: assert property (!start_i |=> $stable(cfg_q)) // RULE_17
    else $error("settings changed during a test");
  a_eof_stall: assert property (rx_valid_i && rdy_q && rx_beat_i.eof
                                |=> !rdy_q && st_q == MSFF_ST_CLASS ##1 rdy_q) // RULE_16
    else $error("stream not held for exactly one cycle after end of frame");

endmodule

// ### bench/msff_src_model.sv
`timescale 1ns/1ps
module msff_src_model
  import msff_pkg::*;
(
  // clock
  input  wire logic clk_i,
  // stream to the bank
  input  wire logic ready_i,
  output logic      valid_o,
  output msff_beat_t beat_o
);
  initial
  begin
    valid_o = 1'b0;
    beat_o  = '0;
  end

  // one frame; each idle gap cycle inverts the data again, so a stale byte shows inverted only on odd gap cycles
  task automatic send(input logic [7:0] fr [64], input int len, input logic tp,
                      input int slow);
    for (int i = 0; i < len; i++)
    begin
      @(negedge clk_i);
      valid_o = 1'b1;
      beat_o  = '{data: fr[i], sof: i == 0, eof: i == len - 1, tpay: tp && i == len - 1};
      while (ready_i !== 1'b1) @(negedge clk_i);
      @(posedge clk_i);
      repeat (i < len - 1 ? slow : 0)
      begin
        @(negedge clk_i);
        valid_o     = 1'b0;
        beat_o.data = ~beat_o.data;
      end
    end
    @(negedge clk_i);
    valid_o     = 1'b0;
    beat_o.data = ~beat_o.data;
  endtask
endmodule

// ### bench/msff_bank_bench.sv
`timescale 1ns/1ps
module msff_bank_bench
  import msff_pkg::*;
;
  logic                          clk_i;
  logic                          reset_i;
  logic                          start_i;
  msff_filt_t [FILTERS-1:0]      cfg;
  msff_flow_t [FILTERS-1:0]      own;
  msff_flow_t [FILTERS-1:0]      peer;
  logic                          rx_valid;
  msff_beat_t                    rx_beat;
  logic                          rx_ready;
  logic [FILTERS-1:0][CNT_W-1:0] cnt;
  logic [FILTERS-1:0]            tpay;
  logic                          running;
  logic [CNT_W-1:0]              exp_cnt [FILTERS];
  logic [FILTERS-1:0]            exp_tp;
  logic [7:0]                    frm [64];
  int                            err_total;
  int                            num_checks;

  msff_bank u_dut (.clk_i(clk_i), .reset_i(reset_i), .start_i(start_i), .cfg_i(cfg),
    .own_flow_i(own), .peer_flow_i(peer), .rx_valid_i(rx_valid), .rx_beat_i(rx_beat),
    .rx_ready_o(rx_ready), .frame_count_o(cnt), .tpay_seen_o(tpay), .running_o(running));
  msff_src_model u_src (.clk_i(clk_i), .ready_i(rx_ready), .valid_o(rx_valid),
    .beat_o(rx_beat));

  // 125 MHz
  always #4 clk_i = ~clk_i;

  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic msff_flow_t mk_flow(input logic [7:0] b);
    return '{dmac: {40'h02_0000_0000, b}, smac: {40'h02_0000_00FF, b},
      dip: {24'h0A_0000, b}, sip: {24'hC0_A800, b}, dport: {8'h13, b}, sport: {8'h27, b}};
  endfunction

  task automatic put(input logic [5:0] ofs, input logic [47:0] v, input int n);
    for (int i = 0; i < n; i++) frm[ofs + i] = v[47 - 8 * i -: 8];
  endtask

  // untagged ipv4/udp header; sw builds the looped-back view of a flow
  task automatic fill(input msff_flow_t f, input logic sw);
    foreach (frm[i]) frm[i] = 8'h00;
    put(OFS_DMAC, sw ? f.smac : f.dmac, 6);
    put(OFS_SMAC, sw ? f.dmac : f.smac, 6);
    put(OFS_ETYPE, {ETYPE_IP4, 32'h0000_0000}, 2);
    put(OFS_SIP, {sw ? f.dip : f.sip, 16'h0000}, 4);
    put(OFS_DIP, {sw ? f.sip : f.dip, 16'h0000}, 4);
    put(OFS_SPORT, {sw ? f.dport : f.sport, 32'h0000_0000}, 2);
    put(OFS_DPORT, {sw ? f.sport : f.dport, 32'h0000_0000}, 2);
  endtask

  task automatic rule(input int f, input int r, input msff_rmode_t m, input msff_kind_t k,
                      input logic [5:0] o, input logic [47:0] v, input logic [47:0] mk);
    cfg[f].rules[r] = '{m, k, o, v, mk};
  endtask

  task automatic do_start;
    @(negedge clk_i);
    start_i = 1'b1;
    @(negedge clk_i);
    start_i = 1'b0;
    exp_tp  = '0;
    for (int i = 0; i < FILTERS; i++) exp_cnt[i] = '0;
  endtask

  // win of FILTERS or more means no filter may take the frame
  task automatic frame(input int win, input logic tp, input int slow);
    u_src.send(frm, 60, tp, slow);
    // send returns half a cycle after eof was taken: the one stall cycle
    chk(32'(rx_ready), 32'h0000_0000);
    @(negedge clk_i);
    if (win < FILTERS)
    begin
      exp_cnt[win] = exp_cnt[win] + 1;
      if (tp)
        exp_tp[win] = 1'b1;
    end
    for (int i = 0; i < FILTERS; i++) chk(cnt[i], exp_cnt[i]);
    chk(32'(tpay), 32'(exp_tp));
  endtask

  // watchdog, far beyond the thousand or so cycles the sequence needs
  initial
  begin
    #100_000;
    err_total++;
    report_and_stop;
  end

  initial
  begin
    clk_i = 1'b0;
    reset_i = 1'b1;
    start_i = 1'b0;
    cfg = '0;
    err_total = 0;
    num_checks = 0;
    for (int n = 0; n < FILTERS; n++)
    begin
      own[n]  = mk_flow(8'(n));
      peer[n] = mk_flow(8'(n + 8'h80));
    end
    for (int i = 0; i < FILTERS; i++) exp_cnt[i] = '0;
    exp_tp = '0;
    repeat (6) @(negedge clk_i);
    chk(32'(rx_ready), 32'h0000_0000);
    chk(32'(running), 32'h0000_0000);
    reset_i = 1'b0;
    @(negedge clk_i);
    chk(32'(rx_ready), 32'h0000_0001);
    fill(peer[1], 1'b0);
    frame(FILTERS, 1'b1, 0);
    // non-contiguous mask on a payload byte, exact and typed rules elsewhere
    cfg[0].fmode = MSFF_CUSTOM;
    rule(0, 0, MSFF_R_EQUAL, MSFF_K_FIXED, 6'h28, 48'hA500_0000_0000, 48'hC300_0000_0000);
    cfg[1].fmode = MSFF_PEER;
    cfg[2].fmode = MSFF_LOOP;
    cfg[3].fmode = MSFF_CUSTOM;
    rule(3, 0, MSFF_R_IGNORE, MSFF_K_FIXED, OFS_ETYPE, {ETYPE_IP4, 32'h0000_0000},
         48'hFFFF_0000_0000);
    rule(3, 1, MSFF_R_EQUAL, MSFF_K_FIXED, OFS_ETYPE, {ETYPE_IP4, 32'h0000_0000},
         48'hFFFF_0000_0000);
    cfg[4].fmode = MSFF_CUSTOM;
    rule(4, 0, MSFF_R_EQUAL, MSFF_K_MAC, 6'h00, own[4].dmac, 48'hFFFF_FFFF_FFFF);
    cfg[5].fmode = MSFF_CUSTOM;
    rule(5, 0, MSFF_R_EQUAL, MSFF_K_IPV4, 6'h0C, {own[5].sip, 16'h0000}, 48'hFFFF_FFFF_0000);
    rule(5, 1, MSFF_R_EQUAL, MSFF_K_UDP, 6'h02, {own[5].dport, 32'h0000_0000},
         48'hFFFF_0000_0000);
    cfg[6].fmode = MSFF_CUSTOM;
    rule(6, 0, MSFF_R_EQUAL, MSFF_K_FIXED, OFS_ETYPE, {ETYPE_IP4, 32'h0000_0000},
         48'hFFFF_0000_0000);
    do_start;
    chk(32'(running), 32'h0000_0001);
    fill(peer[1], 1'b0);
    frame(1, 1'b1, 0);
    frm[40] = 8'hBD;
    frame(0, 1'b0, 2);
    fill(peer[1], 1'b1);
    frame(6, 1'b0, 0);
    fill(own[2], 1'b1);
    frame(2, 1'b1, 1);
    fill(own[2], 1'b0);
    frame(6, 1'b0, 0);
    fill(peer[2], 1'b1);
    frame(6, 1'b0, 0);
    fill(own[4], 1'b0);
    frame(4, 1'b0, 0);
    fill(own[5], 1'b0);
    frame(5, 1'b1, 0);
    frm[29] = frm[29] ^ 8'h01;
    frame(6, 1'b0, 0);
    fill(own[6], 1'b0);
    frm[12] = 8'h86;
    frm[13] = 8'hDD;
    frame(FILTERS, 1'b0, 0);
    // change without a start must not take effect
    cfg[6].fmode = MSFF_BLOCK;
    fill(own[6], 1'b0);
    frame(6, 1'b0, 0);
    do_start;
    for (int i = 0; i < FILTERS; i++) chk(cnt[i], 32'h0000_0000);
    chk(32'(tpay), 32'h0000_0000);
    frame(FILTERS, 1'b1, 0);
    report_and_stop;
  end
endmodule
